// File: dsu_top.sv
// Purpose: two serial channels with control registers on an Avalon-MM slave
// Assumes: 50 MHz clk; word-indexed address; rxd pins asynchronous
// Notes:   every access takes one wait state
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsu_regs.svh"
module dsu_top (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [1:0]  rxd,
   output logic [1:0]       txd,
   output logic [1:0]       sclk,
   output logic [1:0]       irq_rx,
   output logic [1:0]       irq_tx
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [7:0] reg_index(input logic c, input logic [1:0] k);
      logic [7:0] base;
      base = c ? `DSU_IDX_CH1_CTRL_H : `DSU_IDX_CH0_CTRL_H;
      return base + {6'h00, k};
   endfunction

   // parity bit that makes the nine bits even, or odd when odd is set
   function automatic logic par_of(input logic [7:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction

   function automatic logic [3:0] tx_len(input logic [1:0] m);
      logic [3:0] len;
      unique case (m)
         dsu_pkg::DSU_MODE_SHIFT: len = `DSU_LEN_SHIFT;
         dsu_pkg::DSU_MODE_8BIT:  len = `DSU_LEN_FRAME8;
         default:                 len = `DSU_LEN_FRAME9;
      endcase
      return len;
   endfunction

   dsu_pkg::dsu_state_t s;
   dsu_pkg::dsu_state_t next_s;
   logic [1:0]          tick;

   // ****************************************************************
   // per-channel tick generators
   // ****************************************************************
   for (genvar g = 0; g < 2; g++) begin : g_ch
      dsu_tick_if tif ();
      assign tif.presc_sel = s.ch[g].ctrl_l[`DSU_L_PRESC_HI:`DSU_L_PRESC_LO];
      assign tif.mode      = s.ch[g].ctrl_h[`DSU_H_MODE_HI:`DSU_H_MODE_LO];
      assign tif.reload    = s.ch[g].reload;
      assign tick[g]       = tif.tick;
      dsu_tick u_tick (
         .clk  (clk),
         .rstn (rstn),
         .tif  (tif)
      );
   end

   // ****************************************************************
   // bus slave and channel logic
   // ****************************************************************
   logic             wr_go;
   logic [7:0]       wd;
   dsu_pkg::dsu_chan_t cs;
   dsu_pkg::dsu_chan_t nc;
   logic [1:0]       mode;
   logic             nine;
   logic             rx_in;
   logic             tx_start;
   logic             tx_done;
   logic             fin;
   logic             stop_ok;
   logic             raise;
   logic [7:0]       d8;
   logic             ninth;
   logic [3:0]       dlen;
   logic [7:0]       rv;

   always_comb begin
      next_s   = s;
      wr_go    = avs_write && s.ack && avs_byteenable[0];
      wd       = avs_writedata[7:0];
      cs       = '0;
      nc       = '0;
      mode     = 2'b00;
      nine     = 1'b0;
      rx_in    = 1'b1;
      tx_start = 1'b0;
      tx_done  = 1'b0;
      fin      = 1'b0;
      stop_ok  = 1'b0;
      raise    = 1'b0;
      d8       = 8'h00;
      ninth    = 1'b0;
      dlen     = `DSU_DATA8;
      rv       = 8'h00;
      // one wait state: the answer comes the cycle after the request
      next_s.ack = (avs_read || avs_write) && !s.ack;
      for (int c = 0; c < 2; c++) begin
         cs    = s.ch[c];
         nc    = cs;
         mode  = cs.ctrl_h[`DSU_H_MODE_HI:`DSU_H_MODE_LO];
         nine  = mode[1];
         dlen  = nine ? `DSU_DATA9 : `DSU_DATA8;
         rx_in = cs.rx_sync[1];
         fin   = 1'b0;
         stop_ok = 1'b0;
         tx_done = 1'b0;
         nc.rx_sync = {cs.rx_sync[0], rxd[c]};

         if (avs_address == reg_index(c[0], 2'd0)) rv = cs.ctrl_h;
         if (avs_address == reg_index(c[0], 2'd1)) rv = cs.ctrl_l;
         if (avs_address == reg_index(c[0], 2'd2)) rv = cs.reload;
         if (avs_address == reg_index(c[0], 2'd3)) rv = cs.rx_data;

         // software writes come first so that hardware events win below
         if (wr_go && avs_address == reg_index(c[0], 2'd0)) begin
            nc.ctrl_h = wd;
         end
         if (wr_go && avs_address == reg_index(c[0], 2'd1)) begin
            nc.ctrl_l = wd;
         end
         if (wr_go && avs_address == reg_index(c[0], 2'd2)) begin
            nc.reload = wd;
         end
         // a data write while a transmit frame or a shift-mode receive runs is dropped
         tx_start = wr_go && avs_address == reg_index(c[0], 2'd3) && !cs.tx_busy
                    && !(mode == dsu_pkg::DSU_MODE_SHIFT && cs.rx_st != dsu_pkg::DSU_RX_IDLE);

         // ****************************************************************
         // transmitter
         // ****************************************************************
         if (tx_start) begin
            nc.tx_busy = 1'b1;
            nc.tx_sub  = 4'h0;
            nc.tx_bit  = 4'h0;
            unique case (mode)
               dsu_pkg::DSU_MODE_SHIFT: nc.tx_shift = {3'b111, wd};
               dsu_pkg::DSU_MODE_8BIT:  nc.tx_shift = {2'b11, wd, 1'b0};
               default: begin
                  if (cs.ctrl_l[`DSU_L_AUTOPAR]) begin
                     nc.tx_shift = {1'b1, par_of(wd, cs.ctrl_l[`DSU_L_TX_ODD]), wd, 1'b0};
                  end else begin
                     nc.tx_shift = {1'b1, cs.ctrl_h[`DSU_H_TX_NINTH], wd, 1'b0};
                  end
               end
            endcase
         end else if (cs.tx_busy && tick[c]) begin
            nc.tx_sub = cs.tx_sub + 4'h1;
            if (cs.tx_sub == `DSU_OVS_LAST) begin
               nc.tx_shift = {1'b1, cs.tx_shift[10:1]};
               nc.tx_bit   = cs.tx_bit + 4'h1;
               if (cs.tx_bit == tx_len(mode) - 4'h1) begin
                  nc.tx_busy = 1'b0;
                  tx_done    = 1'b1;
               end
            end
         end
         if (tx_done) begin
            nc.ctrl_l[`DSU_L_TX_PEND] = 1'b1;
         end

         // ****************************************************************
         // receiver
         // ****************************************************************
         unique case (cs.rx_st)
            dsu_pkg::DSU_RX_IDLE: begin
               if (cs.ctrl_h[`DSU_H_RX_EN]) begin
                  if (mode == dsu_pkg::DSU_MODE_SHIFT) begin
                     // shift mode receives only while pending is clear and tx is idle
                     if (!cs.ctrl_h[`DSU_H_RX_PEND] && !cs.tx_busy && !tx_start) begin
                        nc.rx_st  = dsu_pkg::DSU_RX_DATA;
                        nc.rx_sub = 4'h0;
                        nc.rx_bit = 4'h0;
                     end
                  end else if (!rx_in) begin
                     nc.rx_st  = dsu_pkg::DSU_RX_START;
                     nc.rx_sub = 4'h0;
                  end
               end
            end
            dsu_pkg::DSU_RX_START: begin
               if (tick[c]) begin
                  nc.rx_sub = cs.rx_sub + 4'h1;
                  if (cs.rx_sub == `DSU_OVS_MID) begin
                     // a start bit gone high by mid-bit was a glitch
                     nc.rx_st  = rx_in ? dsu_pkg::DSU_RX_IDLE : dsu_pkg::DSU_RX_DATA;
                     nc.rx_sub = 4'h0;
                     nc.rx_bit = 4'h0;
                  end
               end
            end
            dsu_pkg::DSU_RX_DATA: begin
               if (tick[c]) begin
                  nc.rx_sub = cs.rx_sub + 4'h1;
                  if (cs.rx_sub == `DSU_OVS_LAST) begin
                     nc.rx_shift = {rx_in, cs.rx_shift[8:1]};
                     nc.rx_bit   = cs.rx_bit + 4'h1;
                     if (cs.rx_bit == dlen - 4'h1) begin
                        if (mode == dsu_pkg::DSU_MODE_SHIFT) begin
                           nc.rx_st = dsu_pkg::DSU_RX_IDLE;
                           fin      = 1'b1;
                        end else begin
                           nc.rx_st = dsu_pkg::DSU_RX_STOP;
                        end
                     end
                  end
               end
            end
            dsu_pkg::DSU_RX_STOP: begin
               if (tick[c]) begin
                  nc.rx_sub = cs.rx_sub + 4'h1;
                  if (cs.rx_sub == `DSU_OVS_LAST) begin
                     stop_ok  = rx_in;
                     fin      = 1'b1;
                     nc.rx_st = dsu_pkg::DSU_RX_IDLE;
                  end
               end
            end
         endcase
         if (!cs.ctrl_h[`DSU_H_RX_EN]) begin
            nc.rx_st = dsu_pkg::DSU_RX_IDLE;
            fin      = 1'b0;
         end

         // frame complete: filter, store, check parity
         d8    = nine ? nc.rx_shift[7:0] : nc.rx_shift[8:1];
         ninth = nc.rx_shift[8];
         unique case (mode)
            dsu_pkg::DSU_MODE_SHIFT: raise = 1'b1;
            dsu_pkg::DSU_MODE_8BIT:  raise = !cs.ctrl_h[`DSU_H_MCE] || stop_ok;
            default:                 raise = !cs.ctrl_h[`DSU_H_MCE] || ninth;
         endcase
         if (fin && raise) begin
            nc.rx_data = d8;
            nc.ctrl_h[`DSU_H_RX_PEND] = 1'b1;
            if (nine && !cs.ctrl_l[`DSU_L_AUTOPAR]) begin
               nc.ctrl_h[`DSU_H_RX_NINTH] = ninth;
            end
            if (nine && cs.ctrl_l[`DSU_L_AUTOPAR]) begin
               nc.ctrl_l[`DSU_L_PAR_ERR] =
                  ninth != par_of(d8, cs.ctrl_l[`DSU_L_RX_ODD]);
            end
         end

         // ****************************************************************
         // pins
         // ****************************************************************
         nc.txd = nc.tx_busy ? nc.tx_shift[0] : 1'b1;
         // shift clock runs low in the first half of each bit period
         if (mode == dsu_pkg::DSU_MODE_SHIFT && nc.tx_busy) begin
            nc.sclk = nc.tx_sub >= `DSU_OVS_HALF;
         end else if (mode == dsu_pkg::DSU_MODE_SHIFT && nc.rx_st == dsu_pkg::DSU_RX_DATA) begin
            nc.sclk = nc.rx_sub >= `DSU_OVS_HALF;
         end else begin
            nc.sclk = 1'b1;
         end
         next_s.ch[c] = nc;
      end
      if (avs_read && !s.ack) begin
         next_s.rdata = rv;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s            <= '0;
         s.ch[0].txd  <= 1'b1;
         s.ch[1].txd  <= 1'b1;
         s.ch[0].sclk <= 1'b1;
         s.ch[1].sclk <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
   assign avs_readdata    = {24'h000000, s.rdata};
   for (genvar o = 0; o < 2; o++) begin : g_out
      assign txd[o]    = s.ch[o].txd;
      assign sclk[o]   = s.ch[o].sclk;
      assign irq_rx[o] = s.ch[o].ctrl_h[`DSU_H_RX_IE] && s.ch[o].ctrl_h[`DSU_H_RX_PEND];
      assign irq_tx[o] = s.ch[o].ctrl_l[`DSU_L_TX_IE] && s.ch[o].ctrl_l[`DSU_L_TX_PEND];
   end
endmodule // dsu_top
`default_nettype wire

// File: dsu_regs.svh
// Purpose: register indices, field positions, reset values and timing counts
// Assumes: word-indexed register bus, one 8-bit register per word
// Notes:   definitions only
`ifndef DSU_REGS_SVH
`define DSU_REGS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define DSU_IDX_CH0_CTRL_H  8'h14
`define DSU_IDX_CH0_CTRL_L  8'h15
`define DSU_IDX_CH0_BAUD    8'h16
`define DSU_IDX_CH0_DATA    8'h17
`define DSU_IDX_CH1_CTRL_H  8'h18
`define DSU_IDX_CH1_CTRL_L  8'h19
`define DSU_IDX_CH1_BAUD    8'h1a
`define DSU_IDX_CH1_DATA    8'h1b

// ****************************************************************
// high control register fields
// ****************************************************************
`define DSU_H_MODE_HI       7
`define DSU_H_MODE_LO       6
`define DSU_H_MCE           5
`define DSU_H_RX_EN         4
`define DSU_H_TX_NINTH      3
`define DSU_H_RX_NINTH      2
`define DSU_H_RX_IE         1
`define DSU_H_RX_PEND       0

// ****************************************************************
// low control register fields
// ****************************************************************
`define DSU_L_AUTOPAR       7
`define DSU_L_TX_ODD        6
`define DSU_L_RX_ODD        5
`define DSU_L_PAR_ERR       4
`define DSU_L_PRESC_HI      3
`define DSU_L_PRESC_LO      2
`define DSU_L_TX_IE         1
`define DSU_L_TX_PEND       0

// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define DSU_RST_REG         8'h00
`define DSU_OVS_LAST        4'hf
`define DSU_OVS_MID         4'h7
`define DSU_OVS_HALF        4'h8
`define DSU_LEN_SHIFT       4'h8
`define DSU_LEN_FRAME8      4'ha
`define DSU_LEN_FRAME9      4'hb
`define DSU_DATA8           4'h8
`define DSU_DATA9           4'h9

`endif

// File: dsu_pkg.sv
// Purpose: shared types of the dual serial channel block
// Assumes: nothing beyond the register header
// Notes:   one packed struct holds all state of a module
`default_nettype none
package dsu_pkg;

   typedef enum logic [1:0] {
      DSU_MODE_SHIFT = 2'b00,
      DSU_MODE_8BIT  = 2'b01,
      DSU_MODE_9FIX  = 2'b10,
      DSU_MODE_9VAR  = 2'b11
   } dsu_mode_t;

   typedef enum logic [1:0] {
      DSU_RX_IDLE  = 2'b00,
      DSU_RX_START = 2'b01,
      DSU_RX_DATA  = 2'b10,
      DSU_RX_STOP  = 2'b11
   } dsu_rx_st_t;

   typedef struct packed {
      logic [7:0]  ctrl_h;
      logic [7:0]  ctrl_l;
      logic [7:0]  reload;
      logic [7:0]  rx_data;
      logic [1:0]  rx_sync;
      logic        tx_busy;
      logic [3:0]  tx_sub;
      logic [3:0]  tx_bit;
      logic [10:0] tx_shift;
      logic        txd;
      logic        sclk;
      dsu_rx_st_t  rx_st;
      logic [3:0]  rx_sub;
      logic [3:0]  rx_bit;
      logic [8:0]  rx_shift;
   } dsu_chan_t;

   typedef struct packed {
      dsu_chan_t [1:0] ch;
      logic            ack;
      logic [7:0]      rdata;
   } dsu_state_t;

   typedef struct packed {
      logic [2:0] presc;
      logic [7:0] baud;
   } dsu_tick_state_t;

endpackage
`default_nettype wire

// File: dsu_tick_if.sv
// Purpose: carries rate settings to a tick generator and its tick back
// Assumes: all signals on the system clock
// Notes:   tick is a one-cycle pulse at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
interface dsu_tick_if;
   logic [1:0] presc_sel;
   logic [1:0] mode;
   logic [7:0] reload;
   logic       tick;
   modport gen  (input presc_sel, input mode, input reload, output tick);
   modport user (output presc_sel, output mode, output reload, input tick);
endinterface
`default_nettype wire

// File: dsu_tick.sv
// Purpose: channel clock prescaler and baud divider
// Assumes: reload changes only while the channel is idle
// Notes:   tick rate is channel clock over (reload + 1), or channel clock in mode 2
`timescale 1ns/1ps
`default_nettype none
`include "dsu_regs.svh"
module dsu_tick (
   input  wire logic  clk,
   input  wire logic  rstn,
   dsu_tick_if.gen    tif
);
   dsu_pkg::dsu_tick_state_t s;
   dsu_pkg::dsu_tick_state_t next_s;
   logic [2:0] presc_last;
   logic [7:0] baud_last;
   logic       ce;

   // ****************************************************************
   // prescaler select and divider limit
   // ****************************************************************
   always_comb begin
      unique case (tif.presc_sel)
         2'b00: presc_last = 3'h7;
         2'b01: presc_last = 3'h3;
         2'b10: presc_last = 3'h1;
         2'b11: presc_last = 3'h0;
      endcase
      // mode 2 ignores the reload value
      baud_last = (tif.mode == dsu_pkg::DSU_MODE_9FIX) ? 8'h00 : tif.reload;
   end

   assign ce       = (s.presc == presc_last);
   assign tif.tick = ce && (s.baud == baud_last);

   always_comb begin
      next_s = s;
      next_s.presc = ce ? 3'h0 : s.presc + 3'h1;
      if (ce) begin
         next_s.baud = (s.baud == baud_last) ? 8'h00 : s.baud + 8'h01;
      end
      // a limit lowered under a running count wraps at once
      if (s.presc > presc_last) begin
         next_s.presc = 3'h0;
      end
      if (s.baud > baud_last) begin
         next_s.baud = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule // dsu_tick
`default_nettype wire

// File: dsu_assertions.sv
// Purpose: port-level checks of the dual serial block
// Assumes: bound to dsu_top, one clock domain
// Notes:   sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module dsu_assertions (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  rxd,
   input wire logic [1:0]  txd,
   input wire logic [1:0]  sclk,
   input wire logic [1:0]  irq_rx,
   input wire logic [1:0]  irq_tx
);
   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // a write that leaves enable and pending not both set must drop the request
   wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire logic off   = !(avs_writedata[1] && avs_writedata[0]);
   wire logic rd_ok = avs_read && !avs_waitrequest;
   property p_wait;
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("access not one wait state");
   property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("wait without request");
   property p_hi; rd_ok |-> avs_readdata[31:8] == 24'h000000; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_unmap; rd_ok && (avs_address < 8'h14 || avs_address > 8'h1b) |-> avs_readdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_rx0; wr_ok && avs_address == 8'h14 && off |=> !irq_rx[0]; endproperty
   a_rx0: assert property (p_rx0) else $error("rx request 0 not dropped");
   property p_rx1; wr_ok && avs_address == 8'h18 && off |=> !irq_rx[1]; endproperty
   a_rx1: assert property (p_rx1) else $error("rx request 1 not dropped");
   property p_tx0; wr_ok && avs_address == 8'h15 && off |=> !irq_tx[0]; endproperty
   a_tx0: assert property (p_tx0) else $error("tx request 0 not dropped");
   property p_tx1; wr_ok && avs_address == 8'h19 && off |=> !irq_tx[1]; endproperty
   a_tx1: assert property (p_tx1) else $error("tx request 1 not dropped");
   c_tx0: cover property ($rose(irq_tx[0]));
   c_tx1: cover property ($rose(irq_tx[1]));
   c_rx0: cover property ($rose(irq_rx[0]));
endmodule // dsu_assertions
bind dsu_top dsu_assertions chk_u (.clk(clk), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd), .sclk(sclk),
   .irq_rx(irq_rx), .irq_tx(irq_tx));
`default_nettype wire

// File: dsu_station.sv
// Purpose: remote serial station on one channel
// Assumes: BIT system clocks per bit, line driven idle high by the station
// Notes:   decodes txd frames, sends frames on rxd
`timescale 1ns/1ps
`default_nettype none
module dsu_station #(parameter int BIT = 16) (
   input  wire logic       clk,
   input  wire logic       txd,
   input  wire logic [3:0] nbits,
   output logic            rxd,
   output logic            got,
   output logic [8:0]      gdata
);
   // ****************************************************************
   // frame send and receive
   // ****************************************************************
   task send(input logic [8:0] d, input int n);
      @(posedge clk) rxd <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(posedge clk);
         rxd <= d[i];
      end
      repeat (BIT) @(posedge clk);
      rxd <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask
   initial begin
      rxd = 1'b1;
      got = 1'b0;
      gdata = 9'h000;
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge clk);
         gdata <= 9'h000;
         for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(posedge clk);
            gdata[i] <= txd;
         end
         repeat (BIT) @(posedge clk);
         got <= txd;
         @(posedge clk);
         got <= 1'b0;
      end
   end
endmodule // dsu_station
`default_nettype wire

// File: dsu_tb.sv
// Purpose: self-checking bench of the dual serial block
// Assumes: prescaler undivided, sixteen clocks per bit
// Notes:   drivers queue expectations, a monitor compares
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address, d;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   wire  [1:0]  rxd;
   logic [1:0]  txd, sclk, irq_rx, irq_tx, got;
   wire  [3:0]  irqs = {irq_tx, irq_rx};
   logic [8:0]  gd0, gd1;
   logic [31:0] exp_rd[$];
   logic [8:0]  exp_tx0[$], exp_tx1[$];
   logic [7:0]  regs[4] = '{8'h14, 8'h15, 8'h18, 8'h19};
   int          fails, tests_run, seed;
   dsu_top dut_u (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd),
      .txd(txd), .sclk(sclk), .irq_rx(irq_rx), .irq_tx(irq_tx));
   dsu_station st0 (.clk(clk), .txd(txd[0]), .nbits(4'h8), .rxd(rxd[0]), .got(got[0]), .gdata(gd0));
   dsu_station st1 (.clk(clk), .txd(txd[1]), .nbits(4'h9), .rxd(rxd[1]), .got(got[1]), .gdata(gd1));
   // ****************************************************************
   // tasks
   // ****************************************************************
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task conclude;
      $display("counts: run %0d bad %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // request held until the edge that sees waitrequest low
   task acc(input logic w, input logic [7:0] a, input logic [7:0] dd);
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h000000, dd};
      // waitrequest is taken at the rising edge, and the request drops only after it
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_rd.push_back({24'h000000, e});
      acc(1'b0, a, 8'h00);
   endtask
   task wait_hi(input int k);
      int n;
      n = 0;
      while (irqs[k] !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk("irq", {31'h0, irqs[k]}, 32'h1);
   endtask
   // ****************************************************************
   // clock, monitor, watchdog, tests
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (avs_read && !avs_waitrequest) chk("readdata", avs_readdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
      if (got[0]) chk("tx0 frame", {23'h0, gd0}, exp_tx0.size() ? {23'h0, exp_tx0.pop_front()} : 32'hx);
      if (got[1]) chk("tx1 frame", {23'h0, gd1}, exp_tx1.size() ? {23'h0, exp_tx1.pop_front()} : 32'hx);
   end
   initial begin
      #400000;
      fails++;
      conclude;
   end
   initial begin
      seed = 32'h130b29c4;
      fails = 0;
      tests_run = 0;
      rstn = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h1;
      avs_writedata = 32'h0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) rd(regs[i], 8'h00);
      rd(8'h30, 8'h00);
      acc(1'b1, 8'h30, 8'hff);
      rd(8'h30, 8'h00);
      $display("test reset and map done");
      // channel 0, 8-bit frame, second write while busy is dropped
      acc(1'b1, 8'h15, 8'h0e);
      acc(1'b1, 8'h16, 8'h00);
      acc(1'b1, 8'h14, 8'h52);
      d = $random(seed);
      exp_tx0.push_back({1'b0, d});
      acc(1'b1, 8'h17, d);
      acc(1'b1, 8'h17, ~d);
      wait_hi(2);
      rd(8'h15, 8'h0f);
      acc(1'b1, 8'h15, 8'h0e);
      rd(8'h15, 8'h0e);
      $display("test tx0 done");
      d = $random(seed);
      st0.send({1'b0, d}, 8);
      wait_hi(0);
      rd(8'h17, d);
      rd(8'h14, 8'h53);
      acc(1'b1, 8'h14, 8'h42);
      st0.send({1'b0, ~d}, 8);
      repeat (8) @(posedge clk);
      rd(8'h14, 8'h42);
      $display("test rx0 done");
      // channel 1, fixed-rate 9-bit mode ignores reload, odd tx and even rx auto parity
      acc(1'b1, 8'h1a, 8'h03);
      acc(1'b1, 8'h19, 8'hce);
      acc(1'b1, 8'h18, 8'hb0);
      d = $random(seed);
      exp_tx1.push_back({~^d, d});
      acc(1'b1, 8'h1b, d);
      wait_hi(3);
      acc(1'b1, 8'h19, 8'hce);
      d = $random(seed);
      st1.send({1'b0, d}, 9);
      repeat (8) @(posedge clk);
      rd(8'h18, 8'hb0);
      d = $random(seed);
      d[0] = ~^d[7:1];
      st1.send({1'b1, d}, 9);
      repeat (8) @(posedge clk);
      rd(8'h18, 8'hb1);
      chk("irq_rx1", {31'h0, irq_rx[1]}, 32'h0);
      rd(8'h19, 8'hce);
      rd(8'h1b, d);
      st1.send({1'b1, d ^ 8'h01}, 9);
      repeat (8) @(posedge clk);
      rd(8'h19, 8'hde);
      // variable-rate 9-bit mode, no auto parity: ninth-bit field is sent
      acc(1'b1, 8'h1a, 8'h00);
      acc(1'b1, 8'h19, 8'h0e);
      acc(1'b1, 8'h18, 8'hc8);
      d = $random(seed);
      exp_tx1.push_back({1'b1, d});
      acc(1'b1, 8'h1b, d);
      wait_hi(3);
      $display("test ch1 done");
      // reset in mid-run clears the channel 1 control registers and the interrupt requests
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(8'h18, 8'h00);
      rd(8'h19, 8'h00);
      chk("irq after reset", {28'h0, irqs}, 32'h0);
      chk("frames left", exp_tx0.size() + exp_tx1.size(), 32'h0);
      $display("test mid reset done");
      conclude;
   end
endmodule // tb
`default_nettype wire
